// ---- verif/chgst_host_model.sv ----
// host side: reads the status word with a one-cycle read strobe
// assumes the status word is registered on sys_clk
`timescale 1ns/1ps
`default_nettype none
module chgst_host_model (
  // clock
  input wire logic sys_clk,
  // status side
  input wire logic [15:0] status_word,
  output logic status_read
);
  initial status_read = 1'b0;
  task automatic read_word(output logic [15:0] w);
    @(posedge sys_clk);
    status_read <= 1'b1;
    @(posedge sys_clk);
    w = status_word;
    status_read <= 1'b0;
  endtask
endmodule // chgst_host_model
`default_nettype wire

// ---- verif/chgst_upper_props.sv ----
// assertions on the ports of the upper charger status block
// assumes it is bound into every chgst_upper instance
`timescale 1ns/1ps
`default_nettype none
module chgst_upper_props #(
  parameter int CNT_W = 21,
  parameter logic [CNT_W-1:0] DEGLITCH_CYCLES = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // inputs
  input wire logic [15:0] cell_stack_voltage,
  input wire logic [15:0] adapter_input_voltage,
  input wire logic [15:0] charge_voltage,
  input wire logic status_read,
  // outputs
  input wire logic [15:0] charger_status_upper_flags,
  input wire logic alert,
  input wire logic battery_path_gate,
  input wire logic bypass_gate,
  input wire logic charge_enable,
  input wire logic [15:0] regulation_target
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic [15:0] st = charger_status_upper_flags;
  wire logic [16:0] stack_w = {1'b0, cell_stack_voltage};
  wire logic [16:0] adp_w = {1'b0, adapter_input_voltage};
  // run length of recovery beyond the hysteresis band
  logic [CNT_W-1:0] ok_cnt;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || adp_w <= stack_w + 17'h000fa) ok_cnt <= '0;
    else if (ok_cnt != '1) ok_cnt <= ok_cnt + CNT_W'(1);
  end
  low_bits_a: assert property (st[10:0] == 11'h000) else $error("low bits set");
  depleted_gate_a: assert property (st[11] |-> !battery_path_gate)
    else $error("battery gate on");
  wake_target_a: assert property ($past(rst_n, 2) && $past(charge_voltage) == 16'h2328
    |-> regulation_target == 16'h2328) else $error("wake target");
  clamp_max_a: assert property ($past(rst_n, 2) && $past(charge_voltage) > 16'h4b0f
    |-> regulation_target == 16'h4b00) else $error("no clamp");
  gap_off_a: assert property ($past(rst_n, 2) &&
    $past(charge_voltage[15:4]) inside {[12'h385:12'h3e7]}
    |-> !charge_enable && regulation_target == 16'h0000) else $error("gap charges");
  trip_off_a: assert property (bypass_gate && adp_w < stack_w + 17'h00096 |=> !bypass_gate)
    else $error("bypass kept");
  deglitch_a: assert property ($rose(bypass_gate) |-> ok_cnt >= DEGLITCH_CYCLES - CNT_W'(1))
    else $error("bypass early");
  alert_hold_a: assert property (alert && !status_read |=> alert) else $error("alert lost");
  enable_needs_a: assert property (charge_enable |=> st[15] && st[14])
    else $error("charge without adapter or pack");
endmodule // chgst_upper_props
bind chgst_upper chgst_upper_props #(.CNT_W(CNT_W), .DEGLITCH_CYCLES(DEGLITCH_CYCLES))
  u_chgst_upper_props (.sys_clk, .rst_n, .cell_stack_voltage, .adapter_input_voltage,
  .charge_voltage, .status_read, .charger_status_upper_flags, .alert, .battery_path_gate,
  .bypass_gate, .charge_enable, .regulation_target);
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for the upper charger status block
// assumes short deglitch and alert counts and the host model
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, adapter_detect_input = 1'b0;
  logic adapter_detect_low = 1'b0, supply_ok_input = 1'b0;
  logic thermistor_sense_input = 1'b0, learn_cycle = 1'b0, status_read;
  logic [15:0] cell_stack_voltage = 16'h0000, adapter_input_voltage = 16'h0000;
  logic [15:0] charge_voltage = 16'h0000, charger_status_upper_flags, regulation_target, w;
  logic [2:0] dep_select = 3'h0;
  logic alert, battery_path_gate, adapter_path_gate, bypass_gate, charge_enable;
  logic ref_supply_5v, gate_drive_regulator;
  logic [17:0] e;
  logic [15:0] cv_tab [12] = '{16'h2328, 16'h2329, 16'h2edf, 16'h2ee0, 16'h2eef,
    16'h384f, 16'h3850, 16'h3e7f, 16'h3e80, 16'h4b0f, 16'h4b10, 16'h0000};
  int byp_off [5] = '{149, 200, 251, 251, 149};
  int byp_wait [5] = '{3, 40, 8, 20, 2};
  logic byp_exp [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  int error_cnt = 0, checks_done = 0, thr, v;
  integer seed = 32'h26824d78;
  wire [15:0] st = charger_status_upper_flags;
  always #2.5 sys_clk = ~sys_clk;
  chgst_upper #(.DEGLITCH_CYCLES(21'h000010), .ALERT_CYCLES(21'h000014)) u_chgst_upper (
    .sys_clk, .rst_n, .adapter_detect_input, .adapter_detect_low, .supply_ok_input,
    .thermistor_sense_input, .cell_stack_voltage, .adapter_input_voltage, .dep_select,
    .learn_cycle, .charge_voltage, .status_read, .charger_status_upper_flags, .alert,
    .battery_path_gate, .adapter_path_gate, .bypass_gate, .charge_enable,
    .regulation_target, .ref_supply_5v, .gate_drive_regulator);
  chgst_host_model u_chgst_host_model (.sys_clk, .status_word(st), .status_read);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic look(input int n);
    tick(n);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // {range flag, enable when powered, target}
  function automatic logic [17:0] exp_range(input int v);
    int d;
    d = v & 32'hfff0;
    if (v == 9000) return {2'b01, 16'h2328};
    if ((d >= 12000 && d <= 14400) || (d >= 16000 && d <= 19200)) return {2'b01, d[15:0]};
    if (d > 19200) return {2'b11, 16'h4b00};
    return {2'b10, 16'h0000};
  endfunction
  initial begin
    look(15);
    check(st, 16'h0000, "reset");
    tick(1);
    rst_n <= 1'b1;
    supply_ok_input <= 1'b1;
    look(6);
    check(gate_drive_regulator, 1'b0, "por early");
    tick(1);
    adapter_detect_low <= 1'b1;
    look(6);
    check({gate_drive_regulator, ref_supply_5v}, 2'b10, "por");
    tick(1);
    adapter_detect_input <= 1'b1;
    thermistor_sense_input <= 1'b1;
    adapter_input_voltage <= 16'h4e20;
    look(6);
    check({ref_supply_5v, st[15:14]}, 3'b111, "adapter");
    $display("power-up done");
    for (int i = 0; i < 20; i++) begin
      v = (i < 12) ? cv_tab[i] : 16'($random(seed));
      tick(1);
      charge_voltage <= 16'(v);
      look(3);
      e = exp_range(v);
      check(regulation_target, e[15:0], "target");
      check(charge_enable, e[16], "enable");
      check(st[12], e[17], "range flag");
    end
    $display("range done");
    tick(1);
    learn_cycle <= 1'b1;
    cell_stack_voltage <= 16'h4e20;
    for (int i = 0; i < 16; i++) begin
      thr = (2800 + 100 * (i % 8)) * (i < 8 ? 3 : 4);
      tick(1);
      dep_select <= 3'(i % 8);
      charge_voltage <= (i < 8) ? 16'h2ee0 : 16'h3e80;
      cell_stack_voltage <= 16'(thr - 1);
      look(4);
      check({st[11], battery_path_gate, adapter_path_gate}, 3'b101, "depleted");
      tick(1);
      cell_stack_voltage <= 16'(thr);
      look(4);
      check({st[11], battery_path_gate, adapter_path_gate}, 3'b010, "not depleted");
    end
    $display("depletion done");
    for (int i = 0; i < 5; i++) begin
      tick(1);
      cell_stack_voltage <= 16'h2ee0;
      adapter_input_voltage <= 16'(12000 + byp_off[i]);
      look(byp_wait[i]);
      check(bypass_gate, byp_exp[i], "bypass");
    end
    tick(1);
    adapter_input_voltage <= 16'h2edf;
    look(3);
    check(st[13], 1'b1, "reverse");
    $display("bypass done");
    // second read: a change just before the first may still be pending
    u_chgst_host_model.read_word(w);
    look(40);
    u_chgst_host_model.read_word(w);
    look(2);
    // adapter, pack, reverse and depleted (12 V stack under 4 x 3.5 V)
    check(w, 16'he800, "read word");
    check(st, 16'he800, "word after read");
    check(alert, 1'b0, "read alert");
    tick(1);
    thermistor_sense_input <= 1'b0;
    look(6);
    check({charge_enable, st[14], alert}, 3'b000, "pack removed");
    look(12);
    check(alert, 1'b0, "alert early");
    look(18);
    check(alert, 1'b1, "alert late");
    u_chgst_host_model.read_word(w);
    look(2);
    check(alert, 1'b0, "alert clear");
    $display("alert done");
    tick(1);
    adapter_detect_input <= 1'b0;
    look(6);
    check({st[15], charge_enable, ref_supply_5v}, 3'b000, "adapter gone");
    $display("adapter done");
    test_done();
  end
  initial begin
    #20000;
    error_cnt++;
    test_done();
  end
endmodule // tb
`default_nettype wire

// ---- verilog/chgst_map.svh ----
// constants for the upper charger status flags block
// assumes mV-scaled converter words and a 200 MHz system clock
`ifndef CHGST_MAP_SVH
`define CHGST_MAP_SVH
`define CHGST_BIT_DEPLETED 11
`define CHGST_BIT_RANGE 12
`define CHGST_BIT_REVERSE 13
`define CHGST_BIT_BATTERY 14
`define CHGST_BIT_ADAPTER 15
`define CHGST_STATUS_RESET 16'h0000
`define CHGST_WAKE_MV 16'h2328
`define CHGST_LOW_MIN_MV 16'h2ee0
`define CHGST_LOW_MAX_MV 16'h3840
`define CHGST_HIGH_MIN_MV 16'h3e80
`define CHGST_HIGH_MAX_MV 16'h4b00
`define CHGST_DAC_MASK 16'hfff0
`define CHGST_BYPASS_OFF_MV 16'h0096
`define CHGST_BYPASS_HYST_MV 16'h0064
`define CHGST_DEP_BASE_MV 16'h0af0
`define CHGST_DEP_STEP_MV 16'h0064
`define CHGST_CLK_NS 5
`define CHGST_DEGLITCH_NS 8000000
`define CHGST_ALERT_NS 8000000
`endif

// ---- verilog/chgst_pkg.sv ----
// types shared by the upper charger status flags block
// assumes the constants header is included by users
package chgst_pkg;
  typedef struct packed {
    logic adapter_attached_flag;
    logic battery_present;
    logic reverse_flag;
    logic range_error_flag;
    logic depleted_flag;
  } chgst_flags_s;
  typedef struct packed {
    logic adapter_above_2v4;
    logic adapter_above_1v2;
    logic supply_above_6v5;
    logic pack_attached;
  } chgst_pins_s;
  typedef enum logic [1:0] {
    CHGST_BYP_OFF = 2'b00,
    CHGST_BYP_WAIT = 2'b01,
    CHGST_BYP_ON = 2'b10
  } chgst_byp_e;
endpackage

// ---- verilog/chgst_upper.sv ----
// upper status flags, power path and range checking of a charger
// assumes comparator pins are asynchronous and converter words are on sys_clk
`include "chgst_map.svh"
`timescale 1ns/1ps
`default_nettype none
module chgst_upper #(
  parameter int CNT_W = 21,
  parameter logic [CNT_W-1:0] DEGLITCH_CYCLES =
    CNT_W'((`CHGST_DEGLITCH_NS + `CHGST_CLK_NS - 1) / `CHGST_CLK_NS),
  parameter logic [CNT_W-1:0] ALERT_CYCLES =
    CNT_W'((`CHGST_ALERT_NS + `CHGST_CLK_NS - 1) / `CHGST_CLK_NS)
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // comparator pins
  input wire logic adapter_detect_input,
  input wire logic adapter_detect_low,
  input wire logic supply_ok_input,
  input wire logic thermistor_sense_input,
  // converter words in mV
  input wire logic [15:0] cell_stack_voltage,
  input wire logic [15:0] adapter_input_voltage,
  // control register fields
  input wire logic [2:0] dep_select,
  input wire logic learn_cycle,
  input wire logic [15:0] charge_voltage,
  input wire logic status_read,
  // status and alert
  output logic [15:0] charger_status_upper_flags,
  output logic alert,
  // power path and converter control
  output logic battery_path_gate,
  output logic adapter_path_gate,
  output logic bypass_gate,
  output logic charge_enable,
  output logic [15:0] regulation_target,
  output logic ref_supply_5v,
  output logic gate_drive_regulator
);

  // two-stage synchronisers for the comparator pins
  chgst_pkg::chgst_pins_s pins_raw;
  chgst_pkg::chgst_pins_s pins_meta;
  chgst_pkg::chgst_pins_s pins;
  assign pins_raw = '{
    adapter_above_2v4: adapter_detect_input,
    adapter_above_1v2: adapter_detect_low,
    supply_above_6v5: supply_ok_input,
    pack_attached: thermistor_sense_input
  };

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          pins_meta[gi] <= 1'b0;
          pins[gi] <= 1'b0;
        end else begin
          pins_meta[gi] <= pins_raw[gi];
          pins[gi] <= pins_meta[gi];
        end
      end
    end
  endgenerate

  // programmed voltage classification
  logic [15:0] dac_value;
  logic in_wake;
  logic in_low;
  logic in_high;
  logic above_max;
  logic next_range_error;
  logic next_range_disable;
  logic [15:0] next_target;
  logic four_cells;
  assign dac_value = charge_voltage & `CHGST_DAC_MASK;

  always_comb begin
    // wake value sits off the converter grid, so match it before truncation
    in_wake = (charge_voltage == `CHGST_WAKE_MV);
    in_low = (dac_value >= `CHGST_LOW_MIN_MV) && (dac_value <= `CHGST_LOW_MAX_MV);
    in_high = (dac_value >= `CHGST_HIGH_MIN_MV) && (dac_value <= `CHGST_HIGH_MAX_MV);
    above_max = (dac_value > `CHGST_HIGH_MAX_MV);
    next_range_error = !(in_wake || in_low || in_high);
    next_range_disable = next_range_error && !above_max;
    four_cells = in_high || above_max;
    if (above_max) begin
      next_target = `CHGST_HIGH_MAX_MV;
    end else if (next_range_disable) begin
      next_target = 16'h0000;
    end else if (in_wake) begin
      next_target = `CHGST_WAKE_MV;
    end else begin
      next_target = dac_value;
    end
  end

  // depletion threshold scaled by cell count
  logic [15:0] per_cell;
  logic [15:0] pack_threshold;
  always_comb begin
    per_cell = `CHGST_DEP_BASE_MV + 16'(`CHGST_DEP_STEP_MV * dep_select);
    if (four_cells) begin
      pack_threshold = 16'(per_cell << 2);
    end else begin
      pack_threshold = 16'(per_cell + (per_cell << 1));
    end
  end

  // bypass comparisons; sums kept one bit wider to avoid wrap
  logic [16:0] stack_plus_off;
  logic [16:0] stack_plus_on;
  logic bypass_trip;
  logic bypass_recover;
  assign stack_plus_off = {1'b0, cell_stack_voltage} + {1'b0, `CHGST_BYPASS_OFF_MV};
  assign stack_plus_on = stack_plus_off + {1'b0, `CHGST_BYPASS_HYST_MV};
  assign bypass_trip = ({1'b0, adapter_input_voltage} < stack_plus_off);
  assign bypass_recover = ({1'b0, adapter_input_voltage} > stack_plus_on);

  // live flags
  chgst_pkg::chgst_flags_s flags;
  chgst_pkg::chgst_flags_s next_flags;
  always_comb begin
    next_flags.depleted_flag = (cell_stack_voltage < pack_threshold);
    next_flags.range_error_flag = next_range_error;
    next_flags.reverse_flag = (cell_stack_voltage > adapter_input_voltage);
    next_flags.battery_present = pins.pack_attached;
    next_flags.adapter_attached_flag = pins.adapter_above_2v4;
  end

  // flags track conditions every cycle; reads never touch them
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      charger_status_upper_flags <= `CHGST_STATUS_RESET;
    end else begin
      charger_status_upper_flags <= `CHGST_STATUS_RESET;
      charger_status_upper_flags[`CHGST_BIT_DEPLETED] <= flags.depleted_flag;
      charger_status_upper_flags[`CHGST_BIT_RANGE] <= flags.range_error_flag;
      charger_status_upper_flags[`CHGST_BIT_REVERSE] <= flags.reverse_flag;
      charger_status_upper_flags[`CHGST_BIT_BATTERY] <= flags.battery_present;
      charger_status_upper_flags[`CHGST_BIT_ADAPTER] <= flags.adapter_attached_flag;
    end
  end

  // power-on release and reference supply
  logic por_ok;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      por_ok <= 1'b0;
      gate_drive_regulator <= 1'b0;
      ref_supply_5v <= 1'b0;
    end else begin
      por_ok <= pins.adapter_above_1v2 && pins.supply_above_6v5;
      gate_drive_regulator <= por_ok;
      ref_supply_5v <= pins.adapter_above_2v4;
    end
  end

  // charging enable and regulation target
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      charge_enable <= 1'b0;
      regulation_target <= 16'h0000;
    end else begin
      charge_enable <= por_ok && pins.adapter_above_2v4
        && pins.pack_attached
        && !next_range_disable;
      regulation_target <= next_target;
    end
  end

  // system power selector
  logic learn_held;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      learn_held <= 1'b0;
    end else if (learn_cycle) begin
      learn_held <= 1'b1;
    end else if (!flags.depleted_flag) begin
      learn_held <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      battery_path_gate <= 1'b0;
      adapter_path_gate <= 1'b0;
    end else if (flags.depleted_flag) begin
      battery_path_gate <= 1'b0;
      adapter_path_gate <= pins.adapter_above_2v4 && learn_held;
    end else begin
      battery_path_gate <= !pins.adapter_above_2v4 || learn_cycle;
      adapter_path_gate <= pins.adapter_above_2v4 && !learn_cycle;
    end
  end

  // bypass switch: off at once, back on only after a steady recovery
  chgst_pkg::chgst_byp_e byp_state;
  chgst_pkg::chgst_byp_e next_byp_state;
  logic [CNT_W-1:0] byp_count;
  always_comb begin
    next_byp_state = byp_state;
    case (byp_state)
      chgst_pkg::CHGST_BYP_OFF: begin
        if (bypass_recover) begin
          next_byp_state = chgst_pkg::CHGST_BYP_WAIT;
        end
      end
      chgst_pkg::CHGST_BYP_WAIT: begin
        if (!bypass_recover) begin
          next_byp_state = chgst_pkg::CHGST_BYP_OFF;
        end else if (byp_count >= DEGLITCH_CYCLES - CNT_W'(1)) begin
          next_byp_state = chgst_pkg::CHGST_BYP_ON;
        end
      end
      chgst_pkg::CHGST_BYP_ON: begin
        if (bypass_trip) begin
          next_byp_state = chgst_pkg::CHGST_BYP_OFF;
        end
      end
      default: begin
        next_byp_state = chgst_pkg::CHGST_BYP_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      byp_state <= chgst_pkg::CHGST_BYP_OFF;
    end else begin
      byp_state <= next_byp_state;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      byp_count <= '0;
    end else if (byp_state == chgst_pkg::CHGST_BYP_WAIT) begin
      byp_count <= byp_count + CNT_W'(1);
    end else begin
      byp_count <= '0;
    end
  end

  // trip acts on the comparison directly so the switch never lags a cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bypass_gate <= 1'b0;
    end else begin
      bypass_gate <= (next_byp_state == chgst_pkg::CHGST_BYP_ON);
    end
  end

  // alert timing; the first change starts the window and later ones
  // do not restart it, so the delay never exceeds the bound
  logic status_changed;
  logic alert_pending;
  logic [CNT_W-1:0] alert_count;
  chgst_pkg::chgst_flags_s flags_seen;
  assign status_changed = (flags != flags_seen);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flags_seen <= '0;
    end else begin
      flags_seen <= flags;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      alert_pending <= 1'b0;
      alert_count <= '0;
    end else if (alert_pending) begin
      if (alert_count >= ALERT_CYCLES - CNT_W'(1)) begin
        alert_pending <= 1'b0;
        alert_count <= '0;
      end else begin
        alert_count <= alert_count + CNT_W'(1);
      end
    end else if (status_changed && !alert) begin
      alert_pending <= 1'b1;
      alert_count <= '0;
    end
  end

  // raising wins over a read in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      alert <= 1'b0;
    end else if (alert_pending && alert_count >= ALERT_CYCLES - CNT_W'(1)) begin
      alert <= 1'b1;
    end else if (status_read) begin
      alert <= 1'b0;
    end
  end

endmodule // chgst_upper
`default_nettype wire
